// ---- rtl/spr_router.v ----
// Service port clock and data router with AXI4-Lite provisioning registers
//
// Behaviour
// RL1 - Provisioned monitor service enables four ports: two synchronous, two asynchronous.
// RL2 - Master setting drives async port clocks; modem setting disables them, modem supplies.
// RL3 - Input-clock disables sync port clocks; output-clock drives 64 kb/s and enables them.
// RL4 - Port 1 receive data out on east clock; transmit data in on west clock.
// RL5 - Terminal: position 1, east clock in, return clock out to connector.
// RL6 - Repeater: position 2, west clock in, east clock out toward west muldem.
// RL7 - Port 3 transmit uses return clock, answered to receive clock enabled by receive enable.
// RL8 - Port 3 receive clock selectable: return, receive or east clock.
// RL9 - Detected return clock routes through position 3 to processor.
// RL10 - Receive clock as input enables transmit driver; detected transmit clock via position 1.
// RL11 - Detected east clock on port 3 routes through position 2.
// RL12 - Only one async connector and one sync connector used at a time.
// RL13 - Port 4 receive on east clock, transmit on east or west; switch sets transceivers.
// RL14 - East selected: position 1 to processor and sync drivers; output clock if enabled.
// RL15 - West selected: position 2 to processor and both sync transmit drivers.
// RL16 - Termination relay driven from provisioned control, default off.
// RL17 - Daisy chain: only end controller terminated.
// RL18 - Displays enable telemetry drivers; provisioning selects telemetry or station alarms.
// RL19 - Telemetry termination permanently off.
// RL20 - Answer polls only with valid address and respond-to-poll on.
// RL21 - Muldem streams supply east and west clocks and data.
// RL22 - Settings in writable storage; changes applied with drivers quiet first. Termination relay and telemetry outputs follow writes with no quiet gap.
//
// Decided for this implementation: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "spr_defs.vh"
module spr_router
(
	input  wire        aclk,
	input  wire        aresetn,
	// AXI4-Lite slave
	input  wire [3:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [3:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	// Muldem clocks and data
	input  wire        east_clock,
	input  wire        west_clock,
	input  wire        east_rx_stream,
	input  wire        west_rx_stream,
	output reg         east_tx_stream,
	output reg         west_tx_stream,
	// Processor serial channels, clocks toward processor
	output reg  [3:0]  cpu_tx_clock,
	output reg  [3:0]  cpu_rx_clock,
	output reg  [3:0]  cpu_tx_stream,
	input  wire [3:0]  cpu_rx_stream,
	output reg  [3:0]  port_enable,
	// Async connector a (port 2)
	input  wire        async_a_tx_stream,
	output reg         async_a_rx_stream,
	// Async connector b (port 3)
	input  wire        return_clock,
	input  wire        async_b_tx_stream,
	output reg         async_b_rx_stream,
	input  wire        receive_clock_in,
	output reg         receive_clock_out,
	output reg         receive_driver_enable,
	input  wire        transmit_clock_in,
	output reg         transmit_clock_out,
	output reg         transmit_driver_enable,
	output reg         direction_select,
	output reg         async_output_clock,
	output reg         async_output_clock_oe,
	// Sync connectors a and b (port 4)
	input  wire        sync_tx_stream,
	output reg         sync_rx_stream,
	output reg         sync_transmit_clock,
	output reg         sync_transmit_clock_oe,
	output reg         sync_receive_clock,
	output reg         sync_receive_clock_oe,
	output reg         sync_output_clock,
	output reg         sync_output_clock_oe,
	// Termination, telemetry and poll gate
	output reg         termination_relay_drive,
	output reg         telemetry_driver_enable,
	output reg         telemetry_select,
	output reg         telemetry_termination,
	output reg         poll_response_enable
);
	////////////////////////////////////////////////////////////////////////////////
	// Synchronised link inputs and clock detectors
	wire [6:0] raw_in;
	wire [6:0] syn;
	wire [6:0] det;
	wire       div_clk;

	assign raw_in = {transmit_clock_in, receive_clock_in, return_clock,
		west_clock, east_clock, 1'b0, 1'b0};

	// Clock pins are sampled by aclk; data rides on the same delay
	genvar gi;
	generate
		for (gi = 2; gi < 7; gi = gi + 1)
		begin : g_sync
			spr_sync u_sync
			(
				.aclk    (aclk),
				.aresetn (aresetn),
				.din     (raw_in[gi]),
				.dout    (syn[gi]),
				.active  (det[gi])
			);
		end
	endgenerate
	assign syn[1:0] = 2'b00;
	assign det[1:0] = 2'b00;

	wire e_clk  = syn[2];
	wire w_clk  = syn[3];
	wire rt_clk = syn[4];
	wire rx_clk = syn[5];
	wire tx_clk = syn[6];

	// Data pins need two flops too
	reg [5:0] d_meta_q;
	reg [5:0] d_q;
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			d_meta_q <= 6'h00;
			d_q      <= 6'h00;
		end
		else
		begin
			d_meta_q <= {sync_tx_stream, async_b_tx_stream, async_a_tx_stream,
				west_rx_stream, east_rx_stream, 1'b0};
			d_q      <= d_meta_q;
		end
	end

	spr_clkdiv u_div
	(
		.aclk    (aclk),
		.aresetn (aresetn),
		.clk_out (div_clk)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Provisioning storage and AXI4-Lite slave
	reg [`SPR_PROV_WIDTH-1:0] prov_q;
	reg [`SPR_RT_WIDTH-1:0]   route_q;
	reg [`SPR_ADDR_WIDTH-1:0] addr_q;
	reg [3:0]                 aw_q;
	reg                       aw_have_q;
	reg [31:0]                w_q;
	reg [3:0]                 ws_q;
	reg                       w_have_q;
	reg [`SPR_QUIET_WIDTH-1:0] quiet_q;
	wire                      do_wr = aw_have_q && w_have_q && !s_axi_bvalid;
	wire [3:0]                wa = {aw_q[3:2], 2'b00};
	wire                      map_ok = (wa == `SPR_OFF_PROV) || (wa == `SPR_OFF_ROUTE)
		|| (wa == `SPR_OFF_ADDR);

	// Address and data accepted in either order, response after both
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `SPR_RESP_OKAY;
			aw_q          <= 4'h0;
			aw_have_q     <= 1'b0;
			w_q           <= 32'h0000_0000;
			ws_q          <= 4'h0;
			w_have_q      <= 1'b0;
			prov_q        <= `SPR_PROV_RESET;
			route_q       <= `SPR_RT_RESET;
			addr_q        <= `SPR_ADDR_RESET;
			quiet_q       <= {`SPR_QUIET_WIDTH{1'b0}};
		end
		else
		begin
			if (quiet_q != {`SPR_QUIET_WIDTH{1'b0}})
				quiet_q <= quiet_q - 1'b1;
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_q          <= s_axi_awaddr;
				aw_have_q     <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_q          <= s_axi_wdata;
				ws_q         <= s_axi_wstrb;
				w_have_q     <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (do_wr)
			begin
				aw_have_q    <= 1'b0;
				w_have_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= map_ok ? `SPR_RESP_OKAY : `SPR_RESP_SLVERR;
				// Settings held here; provisioning and route changes force a quiet gap
				if (wa == `SPR_OFF_PROV) // RL22
				begin
					if (ws_q[0])
						prov_q[7:0] <= w_q[7:0];
					if (ws_q[1])
						prov_q[8] <= w_q[8];
					quiet_q <= `SPR_QUIET_CYC;
				end
				if (wa == `SPR_OFF_ROUTE && ws_q[0])
				begin
					route_q <= w_q[`SPR_RT_WIDTH-1:0];
					quiet_q <= `SPR_QUIET_CYC;
				end
				if (wa == `SPR_OFF_ADDR && ws_q[0])
					addr_q <= w_q[`SPR_ADDR_WIDTH-1:0];
			end
			if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// Read path, one cycle after the address
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `SPR_RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= `SPR_RESP_OKAY;
			case ({s_axi_araddr[3:2], 2'b00})
				`SPR_OFF_PROV:   s_axi_rdata <= {23'h0, prov_q};
				`SPR_OFF_ROUTE:  s_axi_rdata <= {28'h0, route_q};
				`SPR_OFF_STATUS: s_axi_rdata <= {26'h0, quiet_q != 4'h0, det[6:2]};
				`SPR_OFF_ADDR:   s_axi_rdata <= {24'h0, addr_q};
				default:
				begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= `SPR_RESP_SLVERR;
				end
			endcase
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Routing, driver enables and clock selection
	wire       en     = prov_q[`SPR_PROV_ENABLE] && (quiet_q == 4'h0);
	wire       master = prov_q[`SPR_PROV_MASTER];
	wire       outclk = prov_q[`SPR_PROV_OUTCLK];
	wire       rep    = prov_q[`SPR_PROV_REPEAT];
	wire [1:0] p3sel  = route_q[`SPR_RT_P3SEL_HI:`SPR_RT_P3SEL_LO];
	wire       p4west = route_q[`SPR_RT_P4WEST];
	wire       p3rxin = route_q[`SPR_RT_P3RXIN];
	reg        p3_rx_sel;
	reg        p3_tx_sel;

	// Port 3 receive clock: return, receive or detected transmit, or east clock; transmit clock is always return
	always @*
	begin
		p3_rx_sel = rt_clk; // RL8
		p3_tx_sel = rt_clk; // RL7
		case (p3sel)
			`SPR_P3_RETURN:  p3_rx_sel = det[4] ? rt_clk : 1'b0; // RL9
			`SPR_P3_RECEIVE: p3_rx_sel = (p3rxin && det[6]) ? tx_clk : rx_clk; // RL10
			`SPR_P3_EAST:    p3_rx_sel = det[2] ? e_clk : 1'b0; // RL11
			default:         p3_rx_sel = 1'b0;
		endcase
	end

	// All outputs registered; quiet gap blanks every clock driver
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			east_tx_stream          <= 1'b0;
			west_tx_stream          <= 1'b0;
			cpu_tx_clock            <= 4'h0;
			cpu_rx_clock            <= 4'h0;
			cpu_tx_stream           <= 4'h0;
			port_enable             <= 4'h0;
			async_a_rx_stream       <= 1'b0;
			async_b_rx_stream       <= 1'b0;
			receive_clock_out       <= 1'b0;
			receive_driver_enable   <= 1'b0;
			transmit_clock_out      <= 1'b0;
			transmit_driver_enable  <= 1'b0;
			direction_select        <= 1'b0;
			async_output_clock      <= 1'b0;
			async_output_clock_oe   <= 1'b0;
			sync_rx_stream          <= 1'b0;
			sync_transmit_clock     <= 1'b0;
			sync_transmit_clock_oe  <= 1'b0;
			sync_receive_clock      <= 1'b0;
			sync_receive_clock_oe   <= 1'b0;
			sync_output_clock       <= 1'b0;
			sync_output_clock_oe    <= 1'b0;
			termination_relay_drive <= 1'b0;
			telemetry_driver_enable <= 1'b0;
			telemetry_select        <= 1'b0;
			telemetry_termination   <= 1'b0;
			poll_response_enable    <= 1'b0;
		end
		else
		begin
			port_enable <= {4{en}}; // RL1
			// Port 1: east clock out, west clock in
			cpu_rx_clock[0]  <= en & e_clk; // RL4
			cpu_tx_clock[0]  <= en & w_clk; // RL4
			east_tx_stream   <= en & cpu_rx_stream[0]; // RL4
			cpu_tx_stream[0] <= en & d_q[2]; // RL21
			// Port 2: terminal position 1 or repeater position 2
			cpu_tx_clock[1]  <= en & (rep ? w_clk : e_clk); // RL5 RL6
			cpu_rx_clock[1]  <= en & (rep ? e_clk : rt_clk); // RL5 RL6
			cpu_tx_stream[1] <= en & (rep ? d_q[2] : d_q[3]); // RL5 RL6
			west_tx_stream   <= en & rep & cpu_rx_stream[1]; // RL6
			async_a_rx_stream <= en & ~rep & cpu_rx_stream[1]; // RL5
			// Port 3
			cpu_tx_clock[2]   <= en & p3_tx_sel; // RL7
			cpu_rx_clock[2]   <= en & p3_rx_sel; // RL8
			cpu_tx_stream[2]  <= en & d_q[4];
			async_b_rx_stream <= en & cpu_rx_stream[2];
			direction_select  <= p3rxin;
			receive_driver_enable  <= en & master & ~p3rxin; // RL2 RL7
			transmit_driver_enable <= en & master & p3rxin; // RL2 RL10
			receive_clock_out      <= en & master & ~p3rxin & div_clk; // RL7
			transmit_clock_out     <= en & master & p3rxin & div_clk; // RL10
			async_output_clock_oe  <= en & master; // RL2
			async_output_clock     <= en & master & div_clk; // RL2
			// Port 4: east in position 1 or west in position 2
			cpu_rx_clock[3]  <= en & e_clk; // RL13
			cpu_tx_clock[3]  <= en & (p4west ? w_clk : e_clk); // RL13 RL14 RL15
			cpu_tx_stream[3] <= en & d_q[5];
			sync_rx_stream   <= en & cpu_rx_stream[3];
			sync_transmit_clock_oe <= en & outclk; // RL3 RL13
			sync_transmit_clock    <= en & outclk & (p4west ? w_clk : e_clk); // RL14 RL15
			sync_receive_clock_oe  <= en & outclk & ~p4west; // RL3 RL14
			sync_receive_clock     <= en & outclk & ~p4west & e_clk; // RL14
			sync_output_clock_oe   <= en & outclk; // RL3
			// East clock when enabled, else local 64 kb/s divider
			sync_output_clock <= en & outclk & (prov_q[`SPR_PROV_CLKOUTEN] ? e_clk : div_clk); // RL3 RL14
			// Termination and telemetry
			termination_relay_drive <= prov_q[`SPR_PROV_TERM]; // RL16
			telemetry_driver_enable <= prov_q[`SPR_PROV_DISPLAYS]; // RL18
			telemetry_select        <= prov_q[`SPR_PROV_TELESEL]; // RL18
			telemetry_termination   <= 1'b0; // RL19
			poll_response_enable    <= en & prov_q[`SPR_PROV_POLL]
				& (addr_q != `SPR_ADDR_INVALID); // RL20
		end
	end
endmodule

// ---- rtl/spr_defs.vh ----
// Register offsets, field positions, reset values and timing counts of the service port router
`ifndef SPR_DEFS_VH
`define SPR_DEFS_VH
// Register byte offsets
`define SPR_OFF_PROV      4'h0
`define SPR_OFF_ROUTE     4'h4
`define SPR_OFF_STATUS    4'h8
`define SPR_OFF_ADDR      4'hc
// Provisioning register fields
`define SPR_PROV_ENABLE   0
`define SPR_PROV_MASTER   1
`define SPR_PROV_OUTCLK   2
`define SPR_PROV_REPEAT   3
`define SPR_PROV_CLKOUTEN 4
`define SPR_PROV_TERM     5
`define SPR_PROV_DISPLAYS 6
`define SPR_PROV_TELESEL  7
`define SPR_PROV_POLL     8
`define SPR_PROV_WIDTH    9
`define SPR_PROV_RESET    9'h000
// Route register fields
`define SPR_RT_P3SEL_LO   0
`define SPR_RT_P3SEL_HI   1
`define SPR_RT_P4WEST     2
`define SPR_RT_P3RXIN     3
`define SPR_RT_WIDTH      4
`define SPR_RT_RESET      4'h0
// Port 3 receive clock selection codes
`define SPR_P3_RETURN     2'h0
`define SPR_P3_RECEIVE    2'h1
`define SPR_P3_EAST       2'h2
// Monitor address
`define SPR_ADDR_WIDTH    8
`define SPR_ADDR_RESET    8'h00
`define SPR_ADDR_INVALID  8'h00
// Output clock rate and system clock
`define SPR_CLK_HZ        40000000
`define SPR_OUT_BPS       64000
`define SPR_HALF_DIV      ((`SPR_CLK_HZ / `SPR_OUT_BPS) / 2)
`define SPR_DIV_WIDTH     9
// Clock activity detector: window of cycles without an edge
`define SPR_DET_NS        20000
`define SPR_DET_CYC       ((`SPR_DET_NS * 40) / 1000)
`define SPR_DET_WIDTH     10
// Quiet cycles with drivers off while routing changes
`define SPR_QUIET_CYC     4'h8
`define SPR_QUIET_WIDTH   4
// Bus response codes
`define SPR_RESP_OKAY     2'h0
`define SPR_RESP_SLVERR   2'h2
`endif

// ---- rtl/spr_sync.v ----
// Two-flop synchroniser with edge-qualified activity detector
`timescale 1ns/1ps
`include "spr_defs.vh"
module spr_sync
(
	input  wire aclk,
	input  wire aresetn,
	input  wire din,
	output reg  dout,
	output reg  active
);
	reg                       meta_q;
	reg                       last_q;
	reg  [`SPR_DET_WIDTH-1:0] idle_q;

	// First flop feeds only the second
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			meta_q <= 1'b0;
			dout   <= 1'b0;
		end
		else
		begin
			meta_q <= din;
			dout   <= meta_q;
		end
	end

	// Clock counts as detected while edges keep coming within the window
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			last_q <= 1'b0;
			idle_q <= {`SPR_DET_WIDTH{1'b0}};
			active <= 1'b0;
		end
		else
		begin
			last_q <= dout;
			if (dout != last_q)
			begin
				idle_q <= {`SPR_DET_WIDTH{1'b0}};
				active <= 1'b1;
			end
			else if (idle_q == `SPR_DET_CYC)
				active <= 1'b0;
			else
				idle_q <= idle_q + 1'b1;
		end
	end
endmodule

// ---- rtl/spr_clkdiv.v ----
// Free-running divider that makes the 64 kb/s output clock
`timescale 1ns/1ps
`include "spr_defs.vh"
module spr_clkdiv
(
	input  wire aclk,
	input  wire aresetn,
	output reg  clk_out
);
	reg [`SPR_DIV_WIDTH-1:0] cnt_q;

	// Toggle every half period; rate is exact only to the cycle
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cnt_q   <= {`SPR_DIV_WIDTH{1'b0}};
			clk_out <= 1'b0;
		end
		else if (cnt_q == `SPR_HALF_DIV - 1)
		begin
			cnt_q   <= {`SPR_DIV_WIDTH{1'b0}};
			clk_out <= ~clk_out;
		end
		else
			cnt_q <= cnt_q + 1'b1;
	end
endmodule

// ---- verif/spr_chk.sv ----
// Assertion checker for the service port router ports
`timescale 1ns/1ps
`include "spr_defs.vh"
module spr_chk
(
	input wire        aclk,
	input wire        aresetn,
	input wire [3:0]  s_axi_awaddr,
	input wire        s_axi_awvalid,
	input wire        s_axi_awready,
	input wire        s_axi_wvalid,
	input wire        s_axi_wready,
	input wire [1:0]  s_axi_bresp,
	input wire        s_axi_bvalid,
	input wire [31:0] s_axi_rdata,
	input wire        s_axi_rvalid,
	input wire        s_axi_rready,
	input wire        s_axi_arvalid,
	input wire        s_axi_arready,
	input wire [3:0]  port_enable,
	input wire        receive_driver_enable,
	input wire        transmit_driver_enable,
	input wire        direction_select,
	input wire        sync_transmit_clock_oe,
	input wire        sync_receive_clock_oe,
	input wire        sync_output_clock_oe,
	input wire        telemetry_termination
);
////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// Address of the write in flight; bit 3 low means the provisioning or route register
	logic [3:0] aw_q;
	always_ff @(posedge aclk)
	begin
		if (s_axi_awvalid && s_axi_awready)
			aw_q <= s_axi_awaddr;
	end

	// Config write finished, then the blanking gap
	sequence s_cfg_done;
		$rose(s_axi_bvalid) && s_axi_bresp == `SPR_RESP_OKAY && !aw_q[3];
	endsequence
	sequence s_quiet;
		(port_enable == 4'h0) [*4];
	endsequence
	sequence s_wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence

	a_cfg_blank: assert property (s_cfg_done |=> s_quiet)
		else $error("ports not blanked after config write");
	a_term_off: assert property (telemetry_termination == 1'b0)
		else $error("telemetry termination on");
	a_tx_drv_dir: assert property (transmit_driver_enable |-> direction_select)
		else $error("transmit driver on without receive-as-input");
	a_rx_drv_dir: assert property (receive_driver_enable |-> !direction_select)
		else $error("receive driver contends with input clock");
	a_sync_rx_oe: assert property (sync_receive_clock_oe |-> sync_transmit_clock_oe)
		else $error("sync receive clock driven alone");
	a_out_clk_oe: assert property (sync_output_clock_oe |-> sync_transmit_clock_oe)
		else $error("output clock without port clocks");
	a_wr_answer: assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid)
		else $error("write response late");
	a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped before taken");
endmodule
bind spr_router spr_chk u_chk (.*);

// ---- verif/spr_far_model.sv ----
// Far-side model: muldem clocks, return clock echo and muldem data
`timescale 1ns/1ps
module spr_far_model
(
	input  wire [2:0] run,
	input  wire       dat,
	input  wire       receive_clock_out,
	input  wire       receive_driver_enable,
	input  wire       transmit_clock_out,
	input  wire       transmit_driver_enable,
	output logic      transmit_clock_in,
	output logic      east_clock,
	output logic      west_clock,
	output logic      return_clock,
	output logic      east_rx_stream,
	output logic      west_rx_stream
);
////////////////////////////////////////////////////////////////////////////////
	// East muldem clock, 200 ns, off the system clock grid; rests low when stopped
	initial
	begin
		east_clock = 1'b0;
		#7;
		forever #100 east_clock = run[0] ? !east_clock : 1'b0;
	end

	// West muldem clock, own phase so the two never line up
	initial
	begin
		west_clock = 1'b0;
		#31;
		forever #100 west_clock = run[1] ? !west_clock : 1'b0;
	end

	// Remote gear answers only a clock it really receives; one async connector in use
	assign return_clock = run[2] & receive_driver_enable & receive_clock_out;
	// Transmit clock pin reads back only while the device drives it
	assign transmit_clock_in = run[2] & transmit_driver_enable & transmit_clock_out;
	assign east_rx_stream = dat;
	assign west_rx_stream = dat;
endmodule

// ---- verif/test_service_port_clock_data_router.sv ----
// Self-checking bench for the service port router
`timescale 1ns/1ps
`include "spr_defs.vh"
module test_service_port_clock_data_router;
	logic        aclk = 1'b0, aresetn = 1'b0, dat = 1'b0;
	logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
	logic [31:0] s_axi_wdata = 32'h0;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, sync_tx_stream = 1'b0;
	logic        async_a_tx_stream = 1'b0, async_b_tx_stream = 1'b0;
	logic        receive_clock_in = 1'b0, transmit_clock_in;
	logic [3:0]  cpu_rx_stream = 4'h0;
	logic [2:0]  run = 3'h0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic [3:0]  cpu_tx_clock, cpu_rx_clock, cpu_tx_stream, port_enable;
	logic        east_clock, west_clock, return_clock, east_rx_stream, west_rx_stream;
	logic        east_tx_stream, west_tx_stream, async_a_rx_stream, async_b_rx_stream;
	logic        receive_clock_out, receive_driver_enable, transmit_clock_out;
	logic        transmit_driver_enable, direction_select, async_output_clock;
	logic        async_output_clock_oe, sync_rx_stream, sync_transmit_clock;
	logic        sync_transmit_clock_oe, sync_receive_clock, sync_receive_clock_oe;
	logic        sync_output_clock, sync_output_clock_oe, termination_relay_drive;
	logic        telemetry_driver_enable, telemetry_select, telemetry_termination;
	logic        poll_response_enable;
	int          n_mismatch = 0, compares = 0;
////////////////////////////////////////////////////////////////////////////////
	// 40 MHz system clock
	always #12.5 aclk = !aclk;

	spr_router    u_dut (.*);
	spr_far_model u_far (.*);

	// Compare and count
	task automatic chk(input logic [39:0] got, input logic [39:0] exp);
		compares++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic final_report;
		$display("compares=%0d mismatches=%0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Bus write: each channel released at its own handshake
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
		int t;
		t = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			t++;
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		while (!s_axi_bvalid && t < 50);
		s_axi_bready <= 1'b0;
		chk({s_axi_bvalid, s_axi_bresp}, {1'b1, er});
	endtask

	task automatic axi_rd(input logic [3:0] a, input logic [31:0] ex);
		int t;
		t = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			t++;
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end
		while (!s_axi_rvalid && t < 50);
		s_axi_rready <= 1'b0;
		chk({s_axi_rvalid, s_axi_rresp, s_axi_rdata}, {1'b1, `SPR_RESP_OKAY, ex});
	endtask

	// Provision and let the blanking gap pass
	task automatic cfg(input logic [31:0] p, input logic [31:0] r);
		axi_wr(`SPR_OFF_PROV, p, `SPR_RESP_OKAY);
		axi_wr(`SPR_OFF_ROUTE, r, `SPR_RESP_OKAY);
		repeat (20) @(posedge aclk);
	endtask

	task automatic t_regs;
		axi_rd(`SPR_OFF_PROV, 32'h0);
		axi_rd(`SPR_OFF_ROUTE, 32'h0);
		axi_rd(`SPR_OFF_ADDR, 32'h0);
		axi_wr(`SPR_OFF_STATUS, 32'h1, `SPR_RESP_SLVERR);
		axi_wr(`SPR_OFF_ADDR, 32'h5a, `SPR_RESP_OKAY);
		axi_rd(`SPR_OFF_ADDR, 32'h5a);
		chk({termination_relay_drive, port_enable}, 5'h00);
		$display("t_regs done");
	endtask

	// One provisioning bit at a time: relay, telemetry drivers, select, poll
	task automatic t_levels;
		for (int b = 5; b < 9; b++)
		begin
			cfg(32'h1 | (32'h1 << b), 32'h0);
			chk({termination_relay_drive, telemetry_driver_enable, telemetry_select,
				poll_response_enable, telemetry_termination}, 5'h10 >> (b - 5));
		end
		axi_wr(`SPR_OFF_ADDR, 32'h0, `SPR_RESP_OKAY);
		repeat (4) @(posedge aclk);
		chk(poll_response_enable, 1'b0);
		$display("t_levels done");
	endtask

	// Ports come up, drop during a rewrite, return after the gap
	task automatic t_blank;
		cfg(32'h1, 32'h0);
		chk(port_enable, 4'hf);
		axi_wr(`SPR_OFF_PROV, 32'h1, `SPR_RESP_OKAY);
		repeat (2) @(posedge aclk);
		chk(port_enable, 4'h0);
		repeat (14) @(posedge aclk);
		chk(port_enable, 4'hf);
		$display("t_blank done");
	endtask

	// Driver enables for master/modem, output/input clock and direction
	task automatic t_oe;
		run <= 3'h1;
		cfg(32'h17, 32'h0);
		chk({async_output_clock_oe, sync_output_clock_oe, sync_transmit_clock_oe,
			sync_receive_clock_oe, direction_select, transmit_driver_enable,
			receive_driver_enable}, 7'h79);
		cfg(32'h3, 32'h8);
		chk({direction_select, transmit_driver_enable, receive_driver_enable}, 3'h6);
		cfg(32'h1, 32'h0);
		chk({async_output_clock_oe, sync_output_clock_oe, sync_transmit_clock_oe,
			sync_receive_clock_oe, receive_driver_enable}, 5'h00);
		$display("t_oe done");
	endtask

	task automatic t_data;
		run <= 3'h3;
		for (int v = 0; v < 2; v++)
		begin
			cpu_rx_stream <= {4{v[0]}};
			dat <= v[0];
			{async_a_tx_stream, async_b_tx_stream, sync_tx_stream} <= {3{~v[0]}};
			repeat (20) @(posedge aclk);
			chk({east_tx_stream, west_tx_stream, async_a_rx_stream, async_b_rx_stream,
				sync_rx_stream, cpu_tx_stream}, {v[0], 1'b0, {3{v[0]}}, {3{~v[0]}}, v[0]});
		end
		$display("t_data done");
	endtask

	// Selected output follows the source clock and ignores the other one
	task automatic follow(input int k, input logic [2:0] on, input logic [2:0] off);
		int n;
		logic pv;
		logic b;
		for (int p = 0; p < 2; p++)
		begin
			run <= p ? off : on;
			repeat (10) @(posedge aclk);
			n = 0;
			pv = 1'b1;
			repeat (1400)
			begin
				@(posedge aclk);
				b = {sync_receive_clock, sync_transmit_clock, sync_output_clock,
					cpu_tx_clock, cpu_rx_clock} >> k;
				if (b && !pv)
					n++;
				pv = b;
			end
			chk(n != 0, p == 0);
		end
	endtask

	task automatic t_routes;
		cfg(32'h17, 32'h2);
		follow(0, 3'h1, 3'h2);
		follow(4, 3'h2, 3'h1);
		follow(5, 3'h1, 3'h2);
		follow(2, 3'h1, 3'h2);
		follow(3, 3'h1, 3'h2);
		follow(7, 3'h1, 3'h2);
		follow(8, 3'h1, 3'h2);
		follow(9, 3'h1, 3'h2);
		follow(10, 3'h1, 3'h2);
		cfg(32'h0b, 32'h4);
		follow(5, 3'h2, 3'h1);
		follow(1, 3'h1, 3'h2);
		follow(7, 3'h2, 3'h1);
		follow(2, 3'h4, 3'h1);
		cfg(32'h0b, 32'h9);
		follow(2, 3'h4, 3'h1);
		$display("t_routes done");
	endtask

	// Main sequence
	initial
	begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs;
		t_levels;
		t_blank;
		t_oe;
		t_data;
		t_routes;
		final_report;
	end

	// Hang guard, well past the expected run length
	initial
	begin
		repeat (80000) @(posedge aclk);
		n_mismatch++;
		final_report;
	end
endmodule
